// ### design/pnp_link_load.sv
// load capture on the rising edge of the load strobe clock
`timescale 1ns/1ps
module pnp_link_load (
  // link clock and core reset
  input  wire logic                  loadStrobeClock,
  input  wire logic                  srst,
  // pins sampled at the strobe
  input  wire logic [7:0]            dataIn,
  input  wire logic                  xtalAction1,
  input  wire logic                  xtalAction0,
  input  wire logic                  byteSelLo,
  input  wire logic                  byteSelHi2,
  // busy level from the core domain
  input  wire logic                  busy,
  // held load word and its event toggle
  output logic [pnp_pkg::LD_W-1:0]   loadWord,
  output logic                       loadTgl
);
  logic       rstMeta_reg;
  logic       rst_reg;
  logic       busyMeta_reg;
  logic       busy_reg;
  logic [1:0] act;

  assign act = {xtalAction1, xtalAction0};

  // reset and busy brought onto the strobe clock
  always_ff @(posedge loadStrobeClock) begin
    rstMeta_reg  <= srst;
    rst_reg      <= rstMeta_reg;
    busyMeta_reg <= busy;
    busy_reg     <= busyMeta_reg;
  end

  // (R26) capture on strobe
  // word stays put until the next accepted strobe, so the core may read it late
  always_ff @(posedge loadStrobeClock) begin
    if (rst_reg) begin
      loadWord <= '0;
      loadTgl  <= 1'b0;
    end else if (!busy_reg && act != pnp_pkg::ACT_IDLE) begin
      loadWord <= {act, byteSelLo, byteSelHi2, dataIn};
      loadTgl  <= ~loadTgl;
    end
  end
endmodule : pnp_link_load

// ### design/pnp_pkg.sv
// constants shared by the parallel programming port
package pnp_pkg;
  // timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int ENTRY_HOLD_NS  = 10000;
  localparam int ENTRY_HOLD_CYC = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // action bit codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // command bytes
  localparam logic [7:0] CMD_ERASE  = 8'h80;
  localparam logic [7:0] CMD_WFUSE  = 8'h40;
  localparam logic [7:0] CMD_WLOCK  = 8'h20;
  localparam logic [7:0] CMD_WFLASH = 8'h10;
  localparam logic [7:0] CMD_WEE    = 8'h11;
  localparam logic [7:0] CMD_RSIG   = 8'h08;
  localparam logic [7:0] CMD_RFUSE  = 8'h04;
  localparam logic [7:0] CMD_RFLASH = 8'h02;
  localparam logic [7:0] CMD_REE    = 8'h03;
  // reset and erased values
  localparam logic [7:0] FUSE_LO_RST = 8'h62;
  localparam logic [7:0] FUSE_HI_RST = 8'hd9;
  localparam logic [7:0] FUSE_EX_RST = 8'hff;
  localparam logic [7:0] LOCK_ERASED = 8'hff;
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  // field positions
  localparam int FUSE_KEEP_EE_BIT = 3;
  localparam int LD_DATA_LSB      = 0;
  localparam int LD_BS2_BIT       = 8;
  localparam int LD_BS1_BIT       = 9;
  localparam int LD_ACT_LSB       = 10;
  localparam int LD_W             = 12;
  // byte select pairs {hi2, lo} for fuse and lock reads
  localparam logic [1:0] SEL_FUSE_LO = 2'h0;
  localparam logic [1:0] SEL_FUSE_HI = 2'h3;
  localparam logic [1:0] SEL_FUSE_EX = 2'h2;
  localparam logic [1:0] SEL_LOCK    = 2'h1;
  // operation states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ER_FL = 7'h02,
    ST_ER_EE = 7'h04,
    ST_ER_LK = 7'h08,
    ST_PR_FL = 7'h10,
    ST_PR_EE = 7'h20,
    ST_NV_WR = 7'h40
  } pnp_state_t;
endpackage : pnp_pkg

// ### design/pnp_port.sv
// parallel programming port of the nonvolatile memories
// Function
// (R1) done flag low while busy
// (R2) action 00 loads address byte
// (R3) action 01 loads data byte
// (R4) action 10 loads command, 11 idles
// (R5) second selector picks second high byte
// (R6) data bus driven only while output enabled
// (R7) strobes execute the last loaded command
// (R8) write command byte decoding
// (R9) read command byte decoding
// (R10) enter mode on zero pattern, held
// (R11) programmer waits before first command
// (R12) leave mode when reset pin low
// (R13) programmer pulses at least 250 ns
// (R14) command and address retained across operations
// (R15) reload high address per window only
// (R16) erase flash, eeprom, then lock bits
// (R17) keep fuse preserves eeprom on erase
// (R18) erase by write pulse, flag low
// (R19) programmer waits for flag after erase
// (R20) programmer erases before reprogramming
// (R21) flash written through word page buffer
// (R22) eeprom written through byte page buffer
// (R23) calibration byte copied to trim at reset
// (R24) page latch stores data at address
// (R25) write pulse programs the whole page
// (R26) loads sampled on strobe, ignored while busy
`timescale 1ns/1ps
module pnp_port #(
  parameter int         FLASH_AW = 13,
  parameter int         EE_AW    = 9,
  parameter int         FPAGE_AW = 6,
  parameter int         EPAGE_AW = 2,
  parameter logic [7:0] SIG_B0   = 8'h5a, // arbitrary
  parameter logic [7:0] SIG_B1   = 8'h01, // arbitrary
  parameter logic [7:0] SIG_B2   = 8'h02, // arbitrary
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // core clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // link clock
  input  wire logic       loadStrobeClock,
  // control pins
  input  wire logic       hvPresent,
  input  wire logic       pageLatchStrobe,
  input  wire logic       xtalAction1,
  input  wire logic       xtalAction0,
  input  wire logic       byteSelLo,
  input  wire logic       byteSelHi2,
  input  wire logic       writeStrobeN,
  input  wire logic       outDriveN,
  // data bus
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOeN,
  // status
  output logic            progDoneFlag,
  output logic            progMode,
  output logic      [7:0] rcTrimRegister
);
  localparam int FW = 1 << FLASH_AW;
  localparam int EB = 1 << EE_AW;
  localparam int PW = 1 << FPAGE_AW;
  localparam int PB = 1 << EPAGE_AW;

  // refuse geometries the counter and address bytes cannot serve
  if (FLASH_AW > 16 || EE_AW > FLASH_AW || FPAGE_AW >= FLASH_AW || EPAGE_AW >= EE_AW)
  begin : g_bad_geom
    $error("pnp_port: unsupported memory geometry");
  end

  // storage
  logic [15:0] flashMem [0:FW-1];
  logic [7:0]  eeMem    [0:EB-1];
  logic [15:0] flBuf    [0:PW-1];
  logic [7:0]  eeBuf    [0:PB-1];

  // control state
  pnp_pkg::pnp_state_t state_reg;
  pnp_pkg::pnp_state_t state_next;
  logic [FLASH_AW-1:0] idx_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  addrLo_reg;
  logic [7:0]  addrHi_reg;
  logic [7:0]  dataLo_reg;
  logic [7:0]  dataHi_reg;
  logic [7:0]  fuseLo_reg;
  logic [7:0]  fuseHi_reg;
  logic [7:0]  fuseEx_reg;
  logic [7:0]  lock_reg;
  logic [15:0] entCnt_reg;
  logic        entFail_reg;
  logic        wrPrev_reg;
  logic        plPrev_reg;
  logic        tglPrev_reg;

  // synchronised pins
  logic [15:0] pinS;
  logic        tglS;
  logic        hvS;
  logic        plS;
  logic [1:0]  actS;
  logic        bs1S;
  logic        bs2S;
  logic        wrS;
  logic        oeS;
  logic [pnp_pkg::LD_W-1:0] loadWord;
  logic        loadTgl;

  pnp_sync #(.W(16)) u_pin_sync (
    .clk     (mclk),
    .rst     (srst),
    .asyncIn ({hvPresent, pageLatchStrobe, xtalAction1, xtalAction0,
               byteSelLo, byteSelHi2, writeStrobeN, outDriveN, dataIn}),
    .syncOut (pinS)
  );

  pnp_sync #(.W(1)) u_tgl_sync (
    .clk     (mclk),
    .rst     (srst),
    .asyncIn (loadTgl),
    .syncOut (tglS)
  );

  pnp_link_load u_link (
    .loadStrobeClock (loadStrobeClock),
    .srst            (srst),
    .dataIn          (dataIn),
    .xtalAction1     (xtalAction1),
    .xtalAction0     (xtalAction0),
    .byteSelLo       (byteSelLo),
    .byteSelHi2      (byteSelHi2),
    .busy            (!progDoneFlag),
    .loadWord        (loadWord),
    .loadTgl         (loadTgl)
  );

  // pin fields
  assign hvS  = pinS[15];
  assign plS  = pinS[14];
  assign actS = pinS[13:12];
  assign bs1S = pinS[11];
  assign bs2S = pinS[10];
  assign wrS  = pinS[9];
  assign oeS  = pinS[8];

  // load decode; the held word is stable once the toggle has crossed
  wire       loadEv  = (tglS != tglPrev_reg) && progDoneFlag && progMode;
  wire [1:0] ldAct   = loadWord[pnp_pkg::LD_ACT_LSB +: 2];
  wire       ldBs1   = loadWord[pnp_pkg::LD_BS1_BIT];
  wire [7:0] ldByte  = loadWord[pnp_pkg::LD_DATA_LSB +: 8];
  wire       ldAddr  = loadEv && ldAct == pnp_pkg::ACT_ADDR;
  wire       ldData  = loadEv && ldAct == pnp_pkg::ACT_DATA;
  wire       ldCmd   = loadEv && ldAct == pnp_pkg::ACT_CMD;

  // strobe edges and command class
  wire wrFall  = wrPrev_reg && !wrS;
  wire plRise  = !plPrev_reg && plS;
  wire startOp = wrFall && progDoneFlag && progMode;
  wire isRead  = cmd_reg == pnp_pkg::CMD_RSIG || cmd_reg == pnp_pkg::CMD_RFUSE ||
                 cmd_reg == pnp_pkg::CMD_RFLASH || cmd_reg == pnp_pkg::CMD_REE;

  // addressing
  wire [15:0]         addrFull = {addrHi_reg, addrLo_reg};
  wire [FLASH_AW-1:0] flAddr   = addrFull[FLASH_AW-1:0];
  wire [EE_AW-1:0]    eeAddr   = addrFull[EE_AW-1:0];
  wire [FLASH_AW-FPAGE_AW-1:0] flPage = flAddr[FLASH_AW-1:FPAGE_AW];
  wire [EE_AW-EPAGE_AW-1:0]    eePage = eeAddr[EE_AW-1:EPAGE_AW];
  wire [1:0] bsSel  = {bs2S, bs1S};
  wire       keepEe = !fuseHi_reg[pnp_pkg::FUSE_KEEP_EE_BIT];

  // read data selection
  wire [15:0] flWord  = flashMem[flAddr];
  wire [7:0]  sigByte = bs1S ? CAL_BYTE :
                        addrLo_reg == 8'h00 ? SIG_B0 :
                        addrLo_reg == 8'h01 ? SIG_B1 :
                        addrLo_reg == 8'h02 ? SIG_B2 : 8'h00;
  wire [7:0]  fuseByte = bsSel == pnp_pkg::SEL_FUSE_LO ? fuseLo_reg :
                         bsSel == pnp_pkg::SEL_FUSE_HI ? fuseHi_reg :
                         bsSel == pnp_pkg::SEL_FUSE_EX ? fuseEx_reg : lock_reg;
  // (R9) read command decode
  wire [7:0]  readByte = cmd_reg == pnp_pkg::CMD_RFLASH ? (bs1S ? flWord[15:8] : flWord[7:0]) :
                         cmd_reg == pnp_pkg::CMD_REE    ? eeMem[eeAddr] :
                         cmd_reg == pnp_pkg::CMD_RSIG   ? sigByte :
                         cmd_reg == pnp_pkg::CMD_RFUSE  ? fuseByte : 8'h00;

  // end of the current walk over memory
  wire idxLast = (state_reg == pnp_pkg::ST_ER_FL && idx_reg == FLASH_AW'(FW - 1)) ||
                 (state_reg == pnp_pkg::ST_ER_EE && idx_reg == FLASH_AW'(EB - 1)) ||
                 (state_reg == pnp_pkg::ST_PR_FL && idx_reg == FLASH_AW'(PW - 1)) ||
                 (state_reg == pnp_pkg::ST_PR_EE && idx_reg == FLASH_AW'(PB - 1));

  // operation sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pnp_pkg::ST_IDLE: begin
        // (R7) write pulse runs loaded command
        if (startOp) begin
          // (R8) (R18) write command decode, erase on write pulse
          if (cmd_reg == pnp_pkg::CMD_ERASE) begin
            state_next = pnp_pkg::ST_ER_FL;
          end else if (cmd_reg == pnp_pkg::CMD_WFLASH) begin
            state_next = pnp_pkg::ST_PR_FL;
          end else if (cmd_reg == pnp_pkg::CMD_WEE) begin
            state_next = pnp_pkg::ST_PR_EE;
          end else if (cmd_reg == pnp_pkg::CMD_WFUSE || cmd_reg == pnp_pkg::CMD_WLOCK) begin
            state_next = pnp_pkg::ST_NV_WR;
          end
        end
      end
      // (R16) flash first, lock bits last
      pnp_pkg::ST_ER_FL: begin
        if (idxLast) begin
          // (R17) skip eeprom when kept
          state_next = keepEe ? pnp_pkg::ST_ER_LK : pnp_pkg::ST_ER_EE;
        end
      end
      pnp_pkg::ST_ER_EE: begin
        if (idxLast) begin
          state_next = pnp_pkg::ST_ER_LK;
        end
      end
      pnp_pkg::ST_PR_FL,
      pnp_pkg::ST_PR_EE: begin
        if (idxLast) begin
          state_next = pnp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = pnp_pkg::ST_IDLE;
      end
    endcase
  end

  // state, counter and edge history
  always_ff @(posedge mclk) begin
    if (srst || !progMode) begin
      state_reg <= pnp_pkg::ST_IDLE;
      idx_reg   <= '0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= (state_next != state_reg) ? '0 : idx_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPrev_reg  <= 1'b1;
      plPrev_reg  <= 1'b0;
      tglPrev_reg <= 1'b0;
    end else begin
      wrPrev_reg  <= wrS;
      plPrev_reg  <= plS;
      tglPrev_reg <= tglS;
    end
  end

  // (R1) ready flag tracks idle
  always_ff @(posedge mclk) begin
    if (srst) begin
      progDoneFlag <= 1'b1;
    end else begin
      progDoneFlag <= state_next == pnp_pkg::ST_IDLE;
    end
  end

  // (R14) loaded values held until reloaded
  // (R2) (R3) (R4) byte loads by action
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd_reg    <= 8'h00;
      addrLo_reg <= 8'h00;
      addrHi_reg <= 8'h00;
      dataLo_reg <= 8'h00;
      dataHi_reg <= 8'h00;
    end else begin
      if (ldCmd) begin
        cmd_reg <= ldByte;
      end
      if (ldAddr && !ldBs1) begin
        addrLo_reg <= ldByte;
      end
      if (ldAddr && ldBs1) begin
        addrHi_reg <= ldByte;
      end
      if (ldData && !ldBs1) begin
        dataLo_reg <= ldByte;
      end
      if (ldData && ldBs1) begin
        dataHi_reg <= ldByte;
      end
    end
  end

  // (R24) page latch into buffers
  always_ff @(posedge mclk) begin
    if (plRise && progMode && cmd_reg == pnp_pkg::CMD_WFLASH) begin
      // (R21) word index from low address bits
      flBuf[flAddr[FPAGE_AW-1:0]] <= {dataHi_reg, dataLo_reg};
    end
    if (plRise && progMode && cmd_reg == pnp_pkg::CMD_WEE) begin
      // (R22) byte index from low address bits
      eeBuf[eeAddr[EPAGE_AW-1:0]] <= dataLo_reg;
    end
  end

  // memory array writes, one word per cycle
  always_ff @(posedge mclk) begin
    if (state_reg == pnp_pkg::ST_ER_FL) begin
      flashMem[idx_reg] <= {pnp_pkg::BYTE_ERASED, pnp_pkg::BYTE_ERASED};
    end
    // (R25) whole flash page written
    if (state_reg == pnp_pkg::ST_PR_FL) begin
      flashMem[{flPage, idx_reg[FPAGE_AW-1:0]}] <= flBuf[idx_reg[FPAGE_AW-1:0]];
    end
    if (state_reg == pnp_pkg::ST_ER_EE) begin
      eeMem[idx_reg[EE_AW-1:0]] <= pnp_pkg::BYTE_ERASED;
    end
    if (state_reg == pnp_pkg::ST_PR_EE) begin
      eeMem[{eePage, idx_reg[EPAGE_AW-1:0]}] <= eeBuf[idx_reg[EPAGE_AW-1:0]];
    end
  end

  // fuse and lock bytes; fuses survive erase, lock only erased after memory
  always_ff @(posedge mclk) begin
    if (srst) begin
      fuseLo_reg <= pnp_pkg::FUSE_LO_RST;
      fuseHi_reg <= pnp_pkg::FUSE_HI_RST;
      fuseEx_reg <= pnp_pkg::FUSE_EX_RST;
      lock_reg   <= pnp_pkg::LOCK_ERASED;
    end else if (state_reg == pnp_pkg::ST_ER_LK) begin
      // (R16) lock cleared after memory
      lock_reg <= pnp_pkg::LOCK_ERASED;
    end else if (state_reg == pnp_pkg::ST_NV_WR) begin
      if (cmd_reg == pnp_pkg::CMD_WLOCK) begin
        lock_reg <= lock_reg & dataLo_reg; // lock bits only ever program
      end else if (bs2S) begin
        // (R5) second selector picks extended
        fuseEx_reg <= dataLo_reg;
      end else if (bs1S) begin
        fuseHi_reg <= dataLo_reg;
      end else begin
        fuseLo_reg <= dataLo_reg;
      end
    end
  end

  // (R6) bus driven only on read enable
  always_ff @(posedge mclk) begin
    if (srst) begin
      dataOut <= 8'h00;
      dataOeN <= 1'b1;
    end else begin
      dataOut <= readByte;
      dataOeN <= !(progMode && !oeS && isRead);
    end
  end

  // (R10) entry pattern checked and held
  // the pattern must stay zero for the whole hold, else entry waits for hv to drop
  always_ff @(posedge mclk) begin
    if (srst || !hvS) begin
      entCnt_reg  <= 16'h0000;
      entFail_reg <= 1'b0;
      progMode    <= 1'b0;
    end else if (!progMode && !entFail_reg) begin
      if ({plS, actS, bs1S} != 4'h0) begin
        entFail_reg <= 1'b1;
      end else if (entCnt_reg == 16'(pnp_pkg::ENTRY_HOLD_CYC - 1)) begin
        progMode <= 1'b1;
      end else begin
        entCnt_reg <= entCnt_reg + 16'h0001;
      end
    end
  end

  // (R23) calibration copied during reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      rcTrimRegister <= CAL_BYTE;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_busy_flag: assert property (startOp && cmd_reg == pnp_pkg::CMD_ERASE |=> !progDoneFlag) // (R1)
    else $error("done flag not low after erase start");
  a_addr_load: assert property (ldAddr && !ldBs1 |=> addrLo_reg == $past(ldByte)) // (R2)
    else $error("address low byte not loaded");
  a_data_load: assert property (ldData && ldBs1 |=> dataHi_reg == $past(ldByte)) // (R3)
    else $error("data high byte not loaded");
  a_cmd_load: assert property (ldCmd |=> cmd_reg == $past(ldByte)) // (R4)
    else $error("command byte not loaded");
  a_bus_release: assert property (oeS |=> dataOeN) // (R6)
    else $error("bus driven without output enable");
  a_erase_order: assert property (state_reg == pnp_pkg::ST_ER_LK |-> $past(state_reg) != pnp_pkg::ST_IDLE) // (R16)
    else $error("lock erased before memory erase");
  a_keep_eeprom: assert property (state_reg == pnp_pkg::ST_ER_FL && keepEe |=> state_reg != pnp_pkg::ST_ER_EE) // (R17)
    else $error("eeprom erased though kept");
  a_mode_exit: assert property (!hvS |=> !progMode) // (R12)
    else $error("programming mode held without high voltage");
  a_busy_ignore: assert property (!progDoneFlag |=> $stable(cmd_reg) && $stable(addrLo_reg)) // (R26)
    else $error("load accepted while busy");
  a_page_prog: assert property (startOp && cmd_reg == pnp_pkg::CMD_WFLASH |=> state_reg == pnp_pkg::ST_PR_FL) // (R25)
    else $error("page program not started");
endmodule : pnp_port

// ### design/pnp_sync.sv
// two flip-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module pnp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      syncOut  <= '0;
    end else begin
      meta_reg <= asyncIn;
      syncOut  <= meta_reg;
    end
  end
endmodule : pnp_sync

// ### sim/pnp_port_tb_top.sv
// self-checking testbench of the parallel programming port
`timescale 1ns/1ps
module pnp_port_tb_top;
  localparam logic [7:0] SIG0 = 8'h5a; // arbitrary
  localparam logic [7:0] SIG1 = 8'h01; // arbitrary
  localparam logic [7:0] SIG2 = 8'h02; // arbitrary
  localparam logic [7:0] CAL  = 8'h80;
  // default geometry: flash words, eeprom bytes, flash page words
  localparam int         FW   = 8192;
  localparam int         EB   = 512;
  localparam int         PW   = 64;
  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       loadStrobeClock, hvPresent, pageLatchStrobe, xtalAction1, xtalAction0;
  logic       byteSelLo, byteSelHi2, writeStrobeN, outDriveN, dataOeN, progDoneFlag, progMode;
  logic [7:0] dataIn, dataOut, rcTrimRegister, v;
  logic       oen;
  int         errTotal = 0;
  int         samplesChecked = 0;
  int         busyCnt = 0;
  // default geometry, so each erase walks the full flash, and the full eeprom unless kept
  pnp_port i_pnp_port (.mclk(mclk), .srst(srst),
    .loadStrobeClock(loadStrobeClock), .hvPresent(hvPresent), .pageLatchStrobe(pageLatchStrobe),
    .xtalAction1(xtalAction1), .xtalAction0(xtalAction0), .byteSelLo(byteSelLo),
    .byteSelHi2(byteSelHi2), .writeStrobeN(writeStrobeN), .outDriveN(outDriveN), .dataIn(dataIn),
    .dataOut(dataOut), .dataOeN(dataOeN), .progDoneFlag(progDoneFlag), .progMode(progMode),
    .rcTrimRegister(rcTrimRegister));
  pnp_prog_model i_pnp_prog_model (.mclk(mclk), .srst(srst), .dataOut(dataOut), .dataOeN(dataOeN),
    .loadStrobeClock(loadStrobeClock), .hvPresent(hvPresent), .pageLatchStrobe(pageLatchStrobe),
    .xtalAction1(xtalAction1), .xtalAction0(xtalAction0), .byteSelLo(byteSelLo),
    .byteSelHi2(byteSelHi2), .writeStrobeN(writeStrobeN), .outDriveN(outDriveN), .dataIn(dataIn));
  // core clock, 20 ns
  initial forever #10 mclk = ~mclk;
  // busy length counter, cleared by the sequence before each operation
  always @(posedge mclk) if (progDoneFlag === 1'b0) busyCnt <= busyCnt + 1;
  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp8
  task automatic cmpBit(input logic got, input logic exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : cmpBit
  task automatic ld(input logic [1:0] act, input logic sel, input logic [7:0] d);
    i_pnp_prog_model.load(act, sel, d);
  endtask : ld
  task automatic rd(input logic b2, input logic b1, input logic [7:0] exp, input string what);
    i_pnp_prog_model.readByte(b2, b1, v, oen);
    cmp8(v, exp, what);
    cmpBit(oen, 1'b0, "bus driven in read");
    cmpBit(dataOeN, 1'b1, "bus released");
  endtask : rd
  // write pulse, then a bounded wait for the ready flag
  task automatic wrWait();
    int n;
    busyCnt = 0;
    i_pnp_prog_model.wrPulse();
    for (n = 0; n < 10000 && progDoneFlag !== 1'b1; n++) @(posedge mclk);
    if (n == 10000) begin
      errTotal++;
      $display("ERROR %0t ready flag never returned", $time);
      summarize();
    end
    i_pnp_prog_model.hold(1);
  endtask : wrWait
  initial begin
    repeat (16) @(posedge mclk);
    #2;
    srst = 1'b0;
    cmp8(rcTrimRegister, CAL, "trim after reset");
    cmpBit(progDoneFlag & dataOeN & ~progMode, 1'b1, "reset outputs");
    // two strobes clear the link side's synced reset and leave the pins at the zero pattern
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h00);
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h00);
    // entry needs the zero pattern held 500 cycles
    i_pnp_prog_model.hvPresent = 1'b1;
    i_pnp_prog_model.hold(490);
    cmpBit(progMode, 1'b0, "mode too early");
    i_pnp_prog_model.hold(30);
    cmpBit(progMode, 1'b1, "mode entered");
    i_pnp_prog_model.hold(15000);
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_RSIG);
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h00);
    rd(1'b0, 1'b0, SIG0, "signature 0");
    rd(1'b0, 1'b1, CAL, "calibration");
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h01);
    rd(1'b0, 1'b0, SIG1, "signature 1");
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h02);
    rd(1'b0, 1'b0, SIG2, "signature 2");
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_RFUSE);
    ld(pnp_pkg::ACT_IDLE, 1'b0, pnp_pkg::CMD_RFLASH);
    rd(1'b0, 1'b0, pnp_pkg::FUSE_LO_RST, "fuse low");
    rd(1'b1, 1'b1, pnp_pkg::FUSE_HI_RST, "fuse high");
    rd(1'b1, 1'b0, pnp_pkg::FUSE_EX_RST, "fuse ext");
    // erase with a load issued while busy
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_ERASE);
    fork
      wrWait();
      begin
        i_pnp_prog_model.hold(30);
        cmpBit(progDoneFlag, 1'b0, "busy during erase");
        ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_RFUSE);
      end
    join
    cmpBit(busyCnt >= FW + EB, 1'b1, "erase covers both memories");
    ld(pnp_pkg::ACT_IDLE, 1'b0, 8'h00);
    ld(pnp_pkg::ACT_IDLE, 1'b0, 8'h00);
    i_pnp_prog_model.readByte(1'b0, 1'b0, v, oen);
    cmpBit(oen, 1'b1, "load refused while busy");
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_RFUSE);
    rd(1'b0, 1'b1, pnp_pkg::LOCK_ERASED, "lock after erase");
    // one flash word through the page buffer
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_WFLASH);
    ld(pnp_pkg::ACT_ADDR, 1'b1, 8'h00);
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h03);
    ld(pnp_pkg::ACT_DATA, 1'b0, 8'h34);
    ld(pnp_pkg::ACT_DATA, 1'b1, 8'h12);
    i_pnp_prog_model.latch();
    wrWait();
    cmpBit(busyCnt >= PW, 1'b1, "whole page programmed");
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_RFLASH);
    rd(1'b0, 1'b0, 8'h34, "flash low");
    rd(1'b0, 1'b1, 8'h12, "flash high");
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_WEE);
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h02);
    ld(pnp_pkg::ACT_DATA, 1'b0, 8'h5c);
    i_pnp_prog_model.latch();
    wrWait();
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_REE);
    rd(1'b0, 1'b0, 8'h5c, "eeprom byte");
    // program the keep-eeprom fuse in the high byte
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_WFUSE);
    ld(pnp_pkg::ACT_DATA, 1'b0, pnp_pkg::FUSE_HI_RST & 8'hf7);
    i_pnp_prog_model.byteSelLo = 1'b1;
    wrWait();
    i_pnp_prog_model.byteSelLo = 1'b0;
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_WLOCK);
    ld(pnp_pkg::ACT_DATA, 1'b0, 8'hfc);
    wrWait();
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_RFUSE);
    rd(1'b1, 1'b1, pnp_pkg::FUSE_HI_RST & 8'hf7, "fuse high written");
    rd(1'b0, 1'b1, 8'hfc, "lock written");
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_ERASE);
    wrWait();
    cmpBit(busyCnt < FW + EB, 1'b1, "eeprom erase skipped");
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_REE);
    rd(1'b0, 1'b0, 8'h5c, "eeprom kept");
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_RFLASH);
    ld(pnp_pkg::ACT_ADDR, 1'b0, 8'h03);
    rd(1'b0, 1'b1, pnp_pkg::BYTE_ERASED, "flash erased");
    ld(pnp_pkg::ACT_CMD, 1'b0, pnp_pkg::CMD_RFUSE);
    rd(1'b0, 1'b1, pnp_pkg::LOCK_ERASED, "lock cleared");
    rd(1'b1, 1'b1, pnp_pkg::FUSE_HI_RST & 8'hf7, "fuse kept");
    i_pnp_prog_model.hvPresent = 1'b0;
    i_pnp_prog_model.hold(10);
    cmpBit(progMode, 1'b0, "mode left");
    summarize();
  end
endmodule : pnp_port_tb_top

// ### sim/pnp_prog_model.sv
// programmer model driving the parallel programming pins
`timescale 1ns/1ps
module pnp_prog_model (
  // core clock and reset seen by the programmer
  input  wire logic       mclk,
  input  wire logic       srst,
  // device answer on the bus
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOeN,
  // control pins
  output logic            loadStrobeClock,
  output logic            hvPresent,
  output logic            pageLatchStrobe,
  output logic            xtalAction1,
  output logic            xtalAction0,
  output logic            byteSelLo,
  output logic            byteSelHi2,
  output logic            writeStrobeN,
  output logic            outDriveN,
  // resolved bus level
  output logic      [7:0] dataIn
);
  logic       runClk = 1'b0;
  logic       strobe = 1'b0;
  logic       relBus = 1'b0;
  logic [7:0] drvVal = 8'h00;
  // entry pattern
  // pins idle at the all-zero entry pattern and stay there until the first load
  initial begin
    {hvPresent, pageLatchStrobe, xtalAction1, xtalAction0, byteSelLo, byteSelHi2} = 6'h00;
    {writeStrobeN, outDriveN} = 2'h3;
  end
  // link clock runs only in reset so the link side is reset too; between loads it stands low
  initial forever #7.5 runClk = srst ? ~runClk : 1'b0;
  assign loadStrobeClock = runClk | strobe;
  // released bus shows the inverse of the last value, never a stale copy
  assign dataIn = (dataOeN === 1'b0) ? dataOut : (relBus ? ~drvVal : drvVal);
  // all pin changes land just after a core clock edge
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : hold
  task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] d);
    {xtalAction1, xtalAction0} = act;
    byteSelLo = sel;
    drvVal = d;
    hold(2);
    strobe = 1'b1;
    hold(13);
    strobe = 1'b0;
    hold(13);
  endtask : load
  task automatic wrPulse();
    writeStrobeN = 1'b0;
    hold(13);
    writeStrobeN = 1'b1;
    hold(4);
  endtask : wrPulse
  task automatic latch();
    pageLatchStrobe = 1'b1;
    hold(13);
    pageLatchStrobe = 1'b0;
    hold(13);
  endtask : latch
  // read with the bus released by the programmer
  task automatic readByte(input logic b2, input logic b1, output logic [7:0] v, output logic oen);
    byteSelHi2 = b2;
    byteSelLo = b1;
    relBus = 1'b1;
    outDriveN = 1'b0;
    hold(8);
    v = dataIn;
    oen = dataOeN;
    outDriveN = 1'b1;
    hold(8);
    relBus = 1'b0;
  endtask : readByte
endmodule : pnp_prog_model
